/* File: common/amctl_pkg.sv */
// Constants, field layouts and state types for the master-window modifier control
// Assumes a single clock domain shared by the host end and the device end
package amctl_pkg;

  // Device I/O offsets (from the board's base)
  localparam logic [3:0] MODIFIER_REG_OFFSET = 4'h6;
  localparam logic [3:0] PAGE_REG_OFFSET = 4'h4;

  // Field positions of the modifier and window control register
  localparam int MOD_LSB = 8;
  localparam int MOD_MSB = 12;
  localparam int TC_END_BIT = 7;
  localparam int INDIV_BIT = 6;
  localparam int MM_EN_BIT = 4;
  localparam int SEG_MSB = 3;
  localparam logic [15:0] RESERVED_MASK = 16'he020;

  // Values after hard reset
  localparam logic [4:0] MODIFIER_RESET = 5'h00;
  localparam logic [3:0] SEGMENT_RESET = 4'h0;
  localparam logic [15:0] PAGE_RESET = 16'h0000;

  // Host address bits that select the 64 KB window
  localparam int WINDOW_LSB = 16;
  localparam int WINDOW_MSB = 19;

  // Modifier codes
  localparam logic [4:0] AM24_SUP_BLOCK = 5'h1f;
  localparam logic [4:0] AM24_SUP_PROG = 5'h1e;
  localparam logic [4:0] AM24_SUP_DATA = 5'h1d;
  localparam logic [4:0] AM24_NP_BLOCK = 5'h1b;
  localparam logic [4:0] AM24_NP_PROG = 5'h1a;
  localparam logic [4:0] AM24_NP_DATA = 5'h19;
  localparam logic [4:0] AM16_SUP = 5'h15;
  localparam logic [4:0] AM16_PRIORITY_SELECT = 5'h12;
  localparam logic [4:0] AM16_NP = 5'h11;
  localparam logic [4:0] AM_USER_LO = 5'h08;
  localparam logic [4:0] AM_USER_HI = 5'h0f;
  localparam logic [4:0] AM32_SUP_BLOCK = 5'h07;
  localparam logic [4:0] AM32_SUP_PROG = 5'h06;
  localparam logic [4:0] AM32_SUP_DATA = 5'h05;
  localparam logic [4:0] AM32_NP_BLOCK = 5'h03;
  localparam logic [4:0] AM32_NP_PROG = 5'h02;
  localparam logic [4:0] AM32_NP_DATA = 5'h01;

  // Host controller register offsets
  localparam logic [7:0] HOST_IO_DATA = 8'h00;
  localparam logic [7:0] HOST_IO_GO = 8'h04;
  localparam logic [7:0] HOST_MEM_ADDR = 8'h08;
  localparam logic [7:0] HOST_MEM_DATA = 8'h0c;
  localparam logic [7:0] HOST_MEM_GO = 8'h10;
  localparam logic [7:0] HOST_TC = 8'h14;
  localparam logic [7:0] HOST_STATUS = 8'h18;
  localparam logic [7:0] HOST_RDATA = 8'h1c;

  // Lowest segment that host software may open the window on
  localparam logic [3:0] MIN_SEGMENT = 4'h8;

  typedef enum logic [1:0] {EXT_IDLE, EXT_XFER, EXT_HOLD, EXT_LAST} ext_state_type;

endpackage

/* File: common/amctl_link_if.sv */
// Link between the host side (processor and DMA) and the interface board
// Assumes both ends run on the same clock; no clocking block here
`timescale 1ns/1ps
interface amctl_link_if;
  logic io_wr;
  logic [3:0] io_addr;
  logic [1:0] io_be;
  logic [15:0] io_wdata;
  logic mem_req;
  logic mem_wr;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata;
  logic mem_ack;
  logic mem_miss;
  logic [15:0] mem_rdata;
  logic dma_tc;

  modport device_mp (
    input io_wr, io_addr, io_be, io_wdata, mem_req, mem_wr, mem_addr, mem_wdata, dma_tc,
    output mem_ack, mem_miss, mem_rdata
  );
  modport host_mp (
    output io_wr, io_addr, io_be, io_wdata, mem_req, mem_wr, mem_addr, mem_wdata, dma_tc,
    input mem_ack, mem_miss, mem_rdata
  );
endinterface

/* File: design/window_match.sv */
// Compares the programmed segment against the host address bits
// Assumes both inputs are stable in the cycle they are compared
`timescale 1ns/1ps
module window_match #(
  parameter int SEG_W = 4
) (
  // Window setting
  input wire logic enable_in,
  input wire logic [SEG_W-1:0] segment_in,
  // Host address slice
  input wire logic [SEG_W-1:0] addr_slice_in,
  // Result
  output logic hit_out
);
  assign hit_out = enable_in && (segment_in == addr_slice_in);
endmodule

/* File: design/master_window_am_control.sv */
// Board end: modifier and window control register, page register and master-mode cycle engine
// Assumes the host holds mem_req until mem_ack and the expansion bus slave answers with ext_ack_in
`timescale 1ns/1ps

// Operation
// - control register at offset 06, byte/word writes
// - host writes zero to bits 15-13
// - host writes zero to bit 5
// - modifier field drives bus modifier lines
// - 24-bit modifier codes as listed
// - 16-bit modifier codes as listed
// - 32-bit modifier codes as listed
// - user-defined codes pass through unchanged
// - terminal count clears indivisible when enabled
// - terminal count ignored when end-enable clear
// - indivisible sequence keeps other masters out
// - address first transfer only, strobe held
// - host clears indivisible before final transfer
// - clearing indivisible releases address strobe
// - reset and terminal count clear indivisible
// - host sets indivisible before block transfers
// - master enable gates master mode; reset clears
// - host enables master only with proper segment
// - segment compared against host address 19-16
// - page register supplies bus address 31-16
module master_window_am_control (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Host side
  amctl_link_if.device_mp link,
  // Expansion bus side
  output logic ext_req_out,
  output logic ext_wr_out,
  output logic [31:0] ext_addr_out,
  output logic ext_addr_valid_out,
  output logic [4:0] addr_modifier_lines_out,
  output logic addr_strobe_n_out,
  output logic ext_lock_out,
  output logic [15:0] ext_wdata_out,
  input wire logic ext_ack_in,
  input wire logic [15:0] ext_rdata_in,
  // Register view for observation
  output logic master_mode_enable_out,
  output logic indivisible_enable_out
);

  typedef struct packed {
    amctl_pkg::ext_state_type state;
    logic [4:0] master_modifier_field;
    logic tc_end_enable;
    logic indivisible_enable;
    logic master_mode_enable;
    logic [3:0] master_window_segment;
    logic [15:0] master_upper_page_bits;
    logic [15:0] offset;
    logic wr;
    logic [15:0] wdata;
    logic addr_phase;
    logic strobe_n;
    logic req;
    logic lock;
    logic mem_ack;
    logic mem_miss;
    logic [15:0] rdata;
  } dev_state_type;

  localparam dev_state_type DEV_RESET = '{
    state: amctl_pkg::EXT_IDLE,
    master_modifier_field: amctl_pkg::MODIFIER_RESET,
    master_window_segment: amctl_pkg::SEGMENT_RESET,
    master_upper_page_bits: amctl_pkg::PAGE_RESET,
    strobe_n: 1'b1,
    default: '0
  };

  dev_state_type cur_ff;
  dev_state_type nxt_cur;
  logic window_hit;
  logic take_req;

  window_match #(
    .SEG_W(amctl_pkg::WINDOW_MSB - amctl_pkg::WINDOW_LSB + 1)
  ) u_window (
    .enable_in(cur_ff.master_mode_enable),
    .segment_in(cur_ff.master_window_segment),
    .addr_slice_in(link.mem_addr[amctl_pkg::WINDOW_MSB:amctl_pkg::WINDOW_LSB]),
    .hit_out(window_hit)
  );

  // The ack cycle still shows the old request, so it is never taken twice
  assign take_req = link.mem_req && !cur_ff.mem_ack;

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.mem_ack = 1'b0;
    nxt_cur.mem_miss = 1'b0;

    // Terminal count first, so a software write in the same cycle wins
    if (link.dma_tc && cur_ff.tc_end_enable)
    begin
      nxt_cur.indivisible_enable = 1'b0;
    end

    if (link.io_wr && link.io_addr == amctl_pkg::MODIFIER_REG_OFFSET)
    begin
      if (link.io_be[1])
      begin
        nxt_cur.master_modifier_field = link.io_wdata[amctl_pkg::MOD_MSB:amctl_pkg::MOD_LSB];
      end
      if (link.io_be[0])
      begin
        nxt_cur.tc_end_enable = link.io_wdata[amctl_pkg::TC_END_BIT];
        nxt_cur.indivisible_enable = link.io_wdata[amctl_pkg::INDIV_BIT];
        nxt_cur.master_mode_enable = link.io_wdata[amctl_pkg::MM_EN_BIT];
        nxt_cur.master_window_segment = link.io_wdata[amctl_pkg::SEG_MSB:0];
      end
    end
    if (link.io_wr && link.io_addr == amctl_pkg::PAGE_REG_OFFSET)
    begin
      if (link.io_be[1])
      begin
        nxt_cur.master_upper_page_bits[15:8] = link.io_wdata[15:8];
      end
      if (link.io_be[0])
      begin
        nxt_cur.master_upper_page_bits[7:0] = link.io_wdata[7:0];
      end
    end

    unique case (cur_ff.state)
      amctl_pkg::EXT_IDLE:
      begin
        if (take_req && window_hit)
        begin
          nxt_cur.state = amctl_pkg::EXT_XFER;
          nxt_cur.req = 1'b1;
          nxt_cur.offset = link.mem_addr[15:0];
          nxt_cur.wr = link.mem_wr;
          nxt_cur.wdata = link.mem_wdata;
          nxt_cur.addr_phase = 1'b1;
          nxt_cur.strobe_n = 1'b0;
        end
        else if (take_req)
        begin
          nxt_cur.mem_ack = 1'b1;
          nxt_cur.mem_miss = 1'b1;
        end
      end
      amctl_pkg::EXT_XFER:
      begin
        if (ext_ack_in)
        begin
          nxt_cur.req = 1'b0;
          nxt_cur.addr_phase = 1'b0;
          nxt_cur.mem_ack = 1'b1;
          nxt_cur.rdata = ext_rdata_in;
          if (cur_ff.strobe_n)
          begin
            nxt_cur.state = amctl_pkg::EXT_IDLE;
          end
          else if (cur_ff.indivisible_enable)
          begin
            nxt_cur.state = amctl_pkg::EXT_HOLD;
          end
          else
          begin
            nxt_cur.state = amctl_pkg::EXT_IDLE;
            nxt_cur.strobe_n = 1'b1;
          end
        end
      end
      amctl_pkg::EXT_HOLD:
      begin
        if (!cur_ff.indivisible_enable)
        begin
          // Strobe released: the slave now expects exactly one more transfer
          nxt_cur.state = amctl_pkg::EXT_LAST;
          nxt_cur.strobe_n = 1'b1;
        end
        else if (take_req && window_hit)
        begin
          nxt_cur.state = amctl_pkg::EXT_XFER;
          nxt_cur.req = 1'b1;
          nxt_cur.offset = link.mem_addr[15:0];
          nxt_cur.wr = link.mem_wr;
          nxt_cur.wdata = link.mem_wdata;
        end
        else if (take_req)
        begin
          nxt_cur.mem_ack = 1'b1;
          nxt_cur.mem_miss = 1'b1;
        end
      end
      amctl_pkg::EXT_LAST:
      begin
        if (take_req && window_hit)
        begin
          nxt_cur.state = amctl_pkg::EXT_XFER;
          nxt_cur.req = 1'b1;
          nxt_cur.offset = link.mem_addr[15:0];
          nxt_cur.wr = link.mem_wr;
          nxt_cur.wdata = link.mem_wdata;
        end
        else if (take_req)
        begin
          nxt_cur.mem_ack = 1'b1;
          nxt_cur.mem_miss = 1'b1;
        end
      end
    endcase

    // Bus stays owned from the first address until the sequence ends
    nxt_cur.lock = (nxt_cur.state != amctl_pkg::EXT_IDLE);
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cur_ff <= DEV_RESET;
    end
    else if (ce_in)
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign ext_req_out = cur_ff.req;
  assign ext_wr_out = cur_ff.wr;
  assign ext_addr_out = {cur_ff.master_upper_page_bits, cur_ff.offset};
  assign ext_addr_valid_out = cur_ff.addr_phase;
  // Every code, reserved and user-defined ones included, goes out as written
  assign addr_modifier_lines_out = cur_ff.master_modifier_field;
  assign addr_strobe_n_out = cur_ff.strobe_n;
  assign ext_lock_out = cur_ff.lock;
  assign ext_wdata_out = cur_ff.wdata;
  assign link.mem_ack = cur_ff.mem_ack;
  assign link.mem_miss = cur_ff.mem_miss;
  assign link.mem_rdata = cur_ff.rdata;
  assign master_mode_enable_out = cur_ff.master_mode_enable;
  assign indivisible_enable_out = cur_ff.indivisible_enable;

endmodule

/* File: design/host_link_master.sv */
// Host end: turns software register accesses into board I/O writes, memory cycles and terminal counts
// Assumes software uses the plain strobe port; the board answers every memory request
`timescale 1ns/1ps
module host_link_master (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Software port
  input wire logic [7:0] sw_addr_in,
  input wire logic [31:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [31:0] sw_rdata_out,
  // Board side
  amctl_link_if.host_mp link
);

  typedef struct packed {
    logic io_wr;
    logic [3:0] io_addr;
    logic [1:0] io_be;
    logic [15:0] io_wdata;
    logic [15:0] io_hold;
    logic mem_req;
    logic mem_wr;
    logic [19:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic miss;
    logic refused;
    logic tc;
    logic [31:0] rdata;
  } host_state_type;

  host_state_type cur_ff;
  host_state_type nxt_cur;
  logic [15:0] clean_data;
  logic to_modifier;
  logic bad_enable;

  assign to_modifier = sw_wdata_in[3:0] == amctl_pkg::MODIFIER_REG_OFFSET;
  // Reserved bits are forced low on the way out
  assign clean_data = to_modifier ? (cur_ff.io_hold & ~amctl_pkg::RESERVED_MASK) : cur_ff.io_hold;
  // An enable with a segment below the window range could take the host down
  assign bad_enable = to_modifier && sw_wdata_in[4] && cur_ff.io_hold[amctl_pkg::MM_EN_BIT]
    && (cur_ff.io_hold[amctl_pkg::SEG_MSB:0] < amctl_pkg::MIN_SEGMENT);

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.io_wr = 1'b0;
    nxt_cur.tc = 1'b0;
    if (link.mem_ack)
    begin
      nxt_cur.mem_req = 1'b0;
      nxt_cur.mem_rdata = link.mem_rdata;
      nxt_cur.miss = link.mem_miss;
    end
    if (sw_wr_in)
    begin
      unique case (sw_addr_in)
        amctl_pkg::HOST_IO_DATA: nxt_cur.io_hold = sw_wdata_in[15:0];
        amctl_pkg::HOST_IO_GO:
        begin
          nxt_cur.refused = bad_enable;
          nxt_cur.io_wr = !bad_enable;
          nxt_cur.io_addr = sw_wdata_in[3:0];
          nxt_cur.io_be = sw_wdata_in[5:4];
          nxt_cur.io_wdata = clean_data;
        end
        amctl_pkg::HOST_MEM_ADDR: nxt_cur.mem_addr = sw_wdata_in[19:0];
        amctl_pkg::HOST_MEM_DATA: nxt_cur.mem_wdata = sw_wdata_in[15:0];
        amctl_pkg::HOST_MEM_GO:
        begin
          if (!cur_ff.mem_req)
          begin
            nxt_cur.mem_req = 1'b1;
            nxt_cur.mem_wr = sw_wdata_in[0];
          end
        end
        amctl_pkg::HOST_TC: nxt_cur.tc = 1'b1;
        default:
        begin
        end
      endcase
    end
    nxt_cur.rdata = 32'h0000_0000;
    if (sw_rd_in && sw_addr_in == amctl_pkg::HOST_STATUS)
    begin
      nxt_cur.rdata = {29'h0, cur_ff.refused, cur_ff.miss, cur_ff.mem_req};
    end
    else if (sw_rd_in && sw_addr_in == amctl_pkg::HOST_RDATA)
    begin
      nxt_cur.rdata = {16'h0000, cur_ff.mem_rdata};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cur_ff <= '0;
    end
    else if (ce_in)
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign sw_rdata_out = cur_ff.rdata;
  assign link.io_wr = cur_ff.io_wr;
  assign link.io_addr = cur_ff.io_addr;
  assign link.io_be = cur_ff.io_be;
  assign link.io_wdata = cur_ff.io_wdata;
  assign link.mem_req = cur_ff.mem_req;
  assign link.mem_wr = cur_ff.mem_wr;
  assign link.mem_addr = cur_ff.mem_addr;
  assign link.mem_wdata = cur_ff.mem_wdata;
  assign link.dma_tc = cur_ff.tc;

endmodule

/* File: testbench/amctl_sva.sv */
// Checker for the host-to-board link and the board's expansion outputs
// Assumes one clock; instantiated beside the link interface in the bench top
`timescale 1ns/1ps
module amctl_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Link
  input wire logic io_wr,
  input wire logic [3:0] io_addr,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [19:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_miss,
  input wire logic dma_tc,
  // Board outputs and the slave acknowledge
  input wire logic ext_req_out,
  input wire logic ext_wr_out,
  input wire logic [31:0] ext_addr_out,
  input wire logic ext_addr_valid_out,
  input wire logic [4:0] addr_modifier_lines_out,
  input wire logic addr_strobe_n_out,
  input wire logic ext_lock_out,
  input wire logic ext_ack_in,
  input wire logic master_mode_enable_out,
  input wire logic indivisible_enable_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic ctl_lo;
  logic tc_en_ff;
  logic nxt_tc_en;
  // The end-enable is not visible at the ports, so it is shadowed from link writes
  assign ctl_lo = io_wr && io_addr == amctl_pkg::MODIFIER_REG_OFFSET && io_be[0];
  always_comb nxt_tc_en = ctl_lo ? io_wdata[amctl_pkg::TC_END_BIT] : tc_en_ff;
  always_ff @(posedge clk_in) tc_en_ff <= reset_in ? 1'b0 : nxt_tc_en;
  sequence done_s;
    ext_req_out && ext_ack_in;
  endsequence
  sequence held_s;
    !ext_req_out && !addr_strobe_n_out && ext_lock_out;
  endsequence
  modifier_drive_a: assert property (io_wr && io_addr == 4'h6 && io_be[1]
    |=> addr_modifier_lines_out == $past(io_wdata[12:8])) else $error("modifier lines not updated");
  ctrl_write_a: assert property (ctl_lo |=> master_mode_enable_out == $past(io_wdata[4])
    && indivisible_enable_out == $past(io_wdata[6])) else $error("control bits not updated");
  tc_clear_a: assert property (dma_tc && tc_en_ff && !ctl_lo |=> !indivisible_enable_out)
    else $error("terminal count did not clear");
  tc_ignore_a: assert property (dma_tc && !tc_en_ff && !ctl_lo
    |=> $stable(indivisible_enable_out)) else $error("terminal count acted while disabled");
  reset_clear_a: assert property ($fell(reset_in) |-> !master_mode_enable_out
    && !indivisible_enable_out && addr_strobe_n_out && !ext_req_out) else $error("reset state wrong");
  first_addr_a: assert property ($rose(ext_req_out)
    |-> ext_addr_valid_out == !$past(ext_lock_out)) else $error("address broadcast wrong");
  strobe_hold_a: assert property (done_s and indivisible_enable_out |=> held_s)
    else $error("strobe not held");
  strobe_release_a: assert property ($fell(indivisible_enable_out) and held_s
    |-> ##[0:1] addr_strobe_n_out) else $error("strobe not released");
  hit_forward_a: assert property ($rose(ext_req_out) |-> mem_req
    && ext_addr_out[15:0] == mem_addr[15:0] && ext_wr_out == mem_wr) else $error("cycle not forwarded");
  miss_answer_a: assert property ($rose(mem_req) && !master_mode_enable_out && !ext_lock_out
    |=> mem_ack && mem_miss) else $error("disabled access not refused");
  req_answer_a: assert property ($rose(mem_req) |-> ##[1:40] mem_ack) else $error("no answer");
endmodule

/* File: testbench/tb_master_window_am_control.sv */
// Bench joining the host end and the board end; the bench acts as expansion slave
// Assumes the software port timing of the host end and a single 250 MHz clock
`timescale 1ns/1ps
module tb_master_window_am_control;
  typedef struct {logic [15:0] ctl; logic [19:0] a; logic wr; logic miss; int stall;} row_type;
  row_type rows [6] = '{'{16'h1f18, 20'h81234, 1'b0, 1'b0, 0}, '{16'h1918, 20'h91234, 1'b0, 1'b1, 0},
    '{16'h1908, 20'h81234, 1'b0, 1'b1, 0}, '{16'h051f, 20'hf0000, 1'b0, 1'b0, 3},
    '{16'h051f, 20'hfffff, 1'b1, 1'b0, 1}, '{16'h051f, 20'heffff, 1'b0, 1'b1, 0}};
  logic [4:0] codes [17] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h1a, 5'h19, 5'h15, 5'h12, 5'h11, 5'h08, 5'h0f,
    5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic ext_ack = 1'b0;
  logic ce = 1'b1;
  logic [31:0] sw_rdata, ext_addr, seen_addr, rd, st;
  logic ext_req, ext_wr, ext_valid, strobe_n, lock, mm_en, indiv_en;
  logic [4:0] am_lines;
  logic [15:0] ext_wdata;
  logic [21:0] seen_bus;
  int n_fail = 0;
  int compares = 0;
  int valids = 0;
  int stall = 0;
  int wait_cnt = 0;
  always #2 clk_in = ~clk_in;
  amctl_link_if link ();
  host_link_master host_link_master_i (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .sw_rdata_out(sw_rdata), .link(link));
  master_window_am_control master_window_am_control_i (.clk_in(clk_in), .reset_in(reset_in),
    .ce_in(ce), .link(link), .ext_req_out(ext_req), .ext_wr_out(ext_wr), .ext_addr_out(ext_addr),
    .ext_addr_valid_out(ext_valid), .addr_modifier_lines_out(am_lines), .addr_strobe_n_out(strobe_n),
    .ext_lock_out(lock), .ext_wdata_out(ext_wdata), .ext_ack_in(ext_ack),
    .ext_rdata_in(ext_ack ? ext_addr[15:0] ^ 16'h5a5a : ~ext_addr[15:0]),
    .master_mode_enable_out(mm_en), .indivisible_enable_out(indiv_en));
  amctl_sva amctl_sva_i (.clk_in(clk_in), .reset_in(reset_in), .io_wr(link.io_wr), .io_addr(link.io_addr),
    .io_be(link.io_be), .io_wdata(link.io_wdata), .mem_req(link.mem_req), .mem_wr(link.mem_wr),
    .mem_addr(link.mem_addr), .mem_ack(link.mem_ack), .mem_miss(link.mem_miss), .dma_tc(link.dma_tc),
    .ext_req_out(ext_req), .ext_wr_out(ext_wr), .ext_addr_out(ext_addr), .ext_addr_valid_out(ext_valid),
    .addr_modifier_lines_out(am_lines), .addr_strobe_n_out(strobe_n), .ext_lock_out(lock),
    .ext_ack_in(ext_ack), .master_mode_enable_out(mm_en), .indivisible_enable_out(indiv_en));
  // Slave: acknowledges after a programmable stall, one ack per cycle request
  always @(posedge clk_in)
  begin
    ext_ack <= 1'b0;
    if (ext_req && !ext_ack)
    begin
      wait_cnt <= (wait_cnt == stall) ? 0 : wait_cnt + 1;
      if (wait_cnt == stall)
      begin
        ext_ack <= 1'b1;
        seen_addr <= ext_addr;
        seen_bus <= {ext_wr, am_lines, ext_wdata};
        valids <= valids + int'(ext_valid);
      end
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One strobe cycle and one idle cycle, so strobes are never re-driven in one step
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic wr, output logic [31:0] r);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= wr;
    sw_rd <= !wr;
    @(posedge clk_in);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 r = sw_rdata;
    @(posedge clk_in);
  endtask
  task automatic dev_wr(input logic [3:0] off, input logic [1:0] be, input logic [15:0] d);
    bus(amctl_pkg::HOST_IO_DATA, {16'h0, d}, 1'b1, rd);
    bus(amctl_pkg::HOST_IO_GO, {26'h0, be, off}, 1'b1, rd);
    repeat (2) @(posedge clk_in);
  endtask
  task automatic mem(input logic [19:0] a, input logic wr);
    bus(amctl_pkg::HOST_MEM_ADDR, {12'h0, a}, 1'b1, rd);
    bus(amctl_pkg::HOST_MEM_DATA, 32'h0000c3c3, 1'b1, rd);
    bus(amctl_pkg::HOST_MEM_GO, {31'h0, wr}, 1'b1, rd);
    st = 32'h1;
    for (int i = 0; i < 50 && st[0]; i++)
      bus(amctl_pkg::HOST_STATUS, 32'h0, 1'b0, st);
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1 check({mm_en, indiv_en, strobe_n, lock, ext_req}, 32'h04);
    check(am_lines, 32'h0);
    @(posedge clk_in);
  endtask
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    do_reset();
    dev_wr(amctl_pkg::PAGE_REG_OFFSET, 2'b11, 16'hab12);
    foreach (rows[i])
    begin
      stall = rows[i].stall;
      dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b11, rows[i].ctl);
      check(am_lines, rows[i].ctl[12:8]);
      mem(rows[i].a, rows[i].wr);
      check(st[1:0], {rows[i].miss, 1'b0});
      if (!rows[i].miss)
      begin
        check(seen_addr, {16'hab12, rows[i].a[15:0]});
        check(seen_bus, {rows[i].wr, rows[i].ctl[12:8], 16'hc3c3});
      end
      bus(amctl_pkg::HOST_RDATA, 32'h0, 1'b0, rd);
      if (!rows[i].miss && !rows[i].wr)
        check(rd[15:0], rows[i].a[15:0] ^ 16'h5a5a);
    end
    foreach (codes[i])
    begin
      dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b10, {3'h0, codes[i], 8'h00});
      check({mm_en, am_lines}, {1'b1, codes[i]});
    end
    // A user-defined code must reach the bus lines during a real cycle
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b10, 16'h0c00);
    mem(20'hf0020, 1'b0);
    check(seen_addr[15:0], 16'h0020);
    check(seen_bus[20:16], 5'h0c);
    stall = 0;
    // Four single cycles so far, each one broadcast its address
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h0058);
    mem(20'h80010, 1'b0);
    check({strobe_n, lock}, 32'h1);
    mem(20'h80012, 1'b1);
    check(valids, 32'd5);
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h0018);
    check({strobe_n, lock}, 32'h3);
    mem(20'h80014, 1'b0);
    check({valids[29:0], strobe_n, lock}, 32'h16);
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h00d8);
    bus(amctl_pkg::HOST_TC, 32'h0, 1'b1, rd);
    repeat (3) @(posedge clk_in);
    check(indiv_en, 32'h0);
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h0058);
    bus(amctl_pkg::HOST_TC, 32'h0, 1'b1, rd);
    repeat (3) @(posedge clk_in);
    check(indiv_en, 32'h1);
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h0013);
    bus(amctl_pkg::HOST_STATUS, 32'h0, 1'b0, rd);
    check({rd[2], mm_en, indiv_en}, 32'h7);
    // Both ends frozen: the write must not land
    ce <= 1'b0;
    dev_wr(amctl_pkg::MODIFIER_REG_OFFSET, 2'b01, 16'h0008);
    ce <= 1'b1;
    check({mm_en, indiv_en}, 32'h3);
    dev_wr(4'h2, 2'b11, 16'h0000);
    bus(8'h20, 32'h0, 1'b0, rd);
    check({rd[30:0], mm_en}, 32'h1);
    do_reset();
    complete_run();
  end
endmodule
